// ### sbbm_top.sv
// Internal memory decoder: SRAM banks, bit alias region, ROM overlay and boot pin check.
// Assumes a core bus that holds each request while o_busy is high; Flash and ROM
// arrays sit outside on a code port that answers in the cycle o_code_req is high.
//
// Operation
// - SRAM is two 32-bit arrays: even words in one, odd in the other.
// - Read after write to the same array waits exactly one extra cycle.
// - Write then read of the other array runs back to back.
// - SRAM decodes from base 0x2000.0000.
// - Bit alias region at 0x2200.0000: base + byte offset*32 + bit*4.
// - Alias access touches one SRAM bit atomically.
// - ROM decodes from base 0x0100.0000.
// - After reset ROM overlays Flash so boot fetches come from ROM.
// - Boot first clears the ROM overlay; Flash then sits at address 0.
// - Boot pin chosen from any pin of ports A to H.
// - ROM holds a two-level function table with main table at 0x0100.0010.
// - DMA reaches SRAM only; Flash and ROM are refused.
`timescale 1ns/100ps
module sbbm_top #(
   parameter logic [31:0] SRAM_SIZE = sbbm_pkg::SRAM_BYTES,
   parameter logic [31:0] ROM_SIZE  = sbbm_pkg::ROM_BYTES,
   parameter int          PERIPHS   = sbbm_pkg::API_PERIPHS
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_req,
   input  wire logic        i_write,
   input  wire logic        i_dma,
   input  wire logic [31:0] i_addr,
   input  wire logic [3:0]  i_be,
   input  wire logic [31:0] i_wdata,
   output logic             o_busy,
   output logic             o_ack,
   output logic             o_error,
   output logic [31:0]      o_rdata,
   output logic             o_code_req,
   output logic             o_code_rom,
   output logic [31:0]      o_code_addr,
   input  wire logic [31:0] i_code_rdata,
   input  wire logic        i_overlay_clear,
   output logic             o_rom_overlay,
   input  wire logic [31:0] i_boot_config_word,
   input  wire logic [63:0] i_gpio,
   output logic             o_boot_pin_level,
   output logic             o_boot_pin_match
);
   localparam int WORDS = int'(SRAM_SIZE >> 2);
   localparam int AW    = $clog2(WORDS);
   localparam logic [31:0] ALIAS_SIZE = SRAM_SIZE << sbbm_pkg::BITBAND_BYTE_SHIFT;

   sbbm_sram_if #(.AW(AW)) sram ();

   sbbm_sram_banks #(.WORDS(WORDS), .AW(AW)) u_banks (
      .i_clk (i_clk),
      .bus   (sram.mem)
   );

   // Window test shared by every region of the map
   function automatic logic in_window(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
      return (a >= base) && (a < base + size);
   endfunction : in_window

   function automatic sbbm_pkg::sbbm_region_t decode(input logic [31:0] a, input logic ovl);
      if (in_window(a, sbbm_pkg::SRAM_BASE, SRAM_SIZE)) begin
         decode = sbbm_pkg::REG_SRAM;
      end else if (in_window(a, sbbm_pkg::BITBAND_BASE, ALIAS_SIZE)) begin
         decode = sbbm_pkg::REG_ALIAS;
      end else if (in_window(a, sbbm_pkg::ROM_BASE, ROM_SIZE)) begin
         decode = sbbm_pkg::REG_ROM;
      end else if (in_window(a, sbbm_pkg::FLASH_BASE, sbbm_pkg::FLASH_BYTES)) begin
         decode = ovl ? sbbm_pkg::REG_ROM : sbbm_pkg::REG_FLASH;
      end else begin
         decode = sbbm_pkg::REG_NONE;
      end
   endfunction : decode

   // Control state
   sbbm_pkg::sbbm_state_t state, next_state;
   logic          busy, next_busy;
   logic          ack, next_ack;
   logic          error, next_error;
   logic [31:0]   rdata, next_rdata;
   logic          code_req, next_code_req;
   logic          code_rom, next_code_rom;
   logic [31:0]   code_addr, next_code_addr;
   logic          table_hit, next_table_hit;
   logic [31:0]   table_entry, next_table_entry;
   logic          overlay, next_overlay;
   logic          last_wr, next_last_wr;
   logic          last_bank, next_last_bank;
   logic [AW-1:0] pend_addr, next_pend_addr;
   logic          pend_bb, next_pend_bb;
   logic [4:0]    pend_bit, next_pend_bit;

   sbbm_pkg::sbbm_region_t region;
   logic [31:0]   sram_off;
   logic [31:0]   alias_off;
   logic [31:0]   tbl_off;
   logic [AW-1:0] cur_addr;
   logic          cur_bb;
   logic [4:0]    cur_bit;
   logic          take;
   logic          sram_hit;
   logic          same_bank_stall;
   logic [31:0]   sram_word;

   assign region    = decode(i_addr, overlay);
   assign sram_off  = i_addr - sbbm_pkg::SRAM_BASE;
   assign alias_off = i_addr - sbbm_pkg::BITBAND_BASE;
   assign tbl_off   = i_addr - sbbm_pkg::ROM_API_TABLE_ADDR;
   assign take      = i_req && (state == sbbm_pkg::ST_IDLE);
   assign sram_hit  = (region == sbbm_pkg::REG_SRAM) || (region == sbbm_pkg::REG_ALIAS);
   assign cur_bb    = (region == sbbm_pkg::REG_ALIAS);
   // Alias offset bits 6:2 are byte lane and bit number, the rest the word
   assign cur_addr  = cur_bb ? alias_off[AW+6:7] : sram_off[AW+1:2];
   assign cur_bit   = cur_bb ? alias_off[6:2] : 5'h00;

   // Only the array just written is blocked; the other bank runs on
   assign same_bank_stall = last_wr && (last_bank == cur_addr[0]);

   always_comb begin
      sram.wr_en   = take && i_write && sram_hit;
      sram.bitband = (state == sbbm_pkg::ST_STALL) ? pend_bb : cur_bb;
      sram.addr    = (state == sbbm_pkg::ST_STALL) ? pend_addr : cur_addr;
      sram.bit_idx = (state == sbbm_pkg::ST_STALL) ? pend_bit : cur_bit;
      sram.be      = i_be;
      sram.wdata   = i_wdata;
   end

   // Alias reads show the single bit in bit 0
   assign sram_word = sram.bitband ? {31'h0, sram.rdata[sram.bit_idx]} : sram.rdata;

   always_comb begin
      next_state       = state;
      next_ack         = 1'b0;
      next_error       = 1'b0;
      next_rdata       = rdata;
      next_code_req    = 1'b0;
      next_code_rom    = code_rom;
      next_code_addr   = code_addr;
      next_table_hit   = table_hit;
      next_table_entry = table_entry;
      unique case (state)
         sbbm_pkg::ST_IDLE: begin
            if (take) begin
               if (sram_hit) begin
                  if (i_write) begin
                     next_ack = 1'b1;
                  end else if (same_bank_stall) begin
                     next_state     = sbbm_pkg::ST_STALL;
                  end else begin
                     next_ack   = 1'b1;
                     next_rdata = sram_word;
                  end
               end else if (region == sbbm_pkg::REG_NONE || i_write || i_dma) begin
                  // DMA has no path to the code bus; code writes belong to the Flash controller
                  next_ack   = 1'b1;
                  next_error = 1'b1;
                  next_rdata = 32'h0000_0000;
               end else begin
                  next_code_req  = 1'b1;
                  next_code_rom  = (region == sbbm_pkg::REG_ROM);
                  next_code_addr = (i_addr >= sbbm_pkg::ROM_BASE) ? i_addr - sbbm_pkg::ROM_BASE : i_addr;
                  next_table_hit = (region == sbbm_pkg::REG_ROM) && (i_addr >= sbbm_pkg::ROM_API_TABLE_ADDR)
                                   && (tbl_off < 32'(PERIPHS * 4));
                  next_table_entry = sbbm_pkg::ROM_BASE + sbbm_pkg::API_SEC_BASE
                                   + 32'((tbl_off >> 2) * sbbm_pkg::API_SEC_SIZE);
                  next_state     = sbbm_pkg::ST_CODE;
               end
            end
         end
         sbbm_pkg::ST_STALL: begin
            next_ack   = 1'b1;
            next_rdata = sram_word;
            next_state = sbbm_pkg::ST_IDLE;
         end
         sbbm_pkg::ST_CODE: begin
            next_ack   = 1'b1;
            next_rdata = table_hit ? table_entry : i_code_rdata;
            next_state = sbbm_pkg::ST_IDLE;
         end
      endcase
      next_busy = (next_state != sbbm_pkg::ST_IDLE);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state       <= sbbm_pkg::ST_IDLE;
         busy        <= 1'b0;
         ack         <= 1'b0;
         error       <= 1'b0;
         rdata       <= 32'h0000_0000;
         code_req    <= 1'b0;
         code_rom    <= 1'b0;
         code_addr   <= 32'h0000_0000;
         table_hit   <= 1'b0;
         table_entry <= 32'h0000_0000;
      end else begin
         state       <= next_state;
         busy        <= next_busy;
         ack         <= next_ack;
         error       <= next_error;
         rdata       <= next_rdata;
         code_req    <= next_code_req;
         code_rom    <= next_code_rom;
         code_addr   <= next_code_addr;
         table_hit   <= next_table_hit;
         table_entry <= next_table_entry;
      end
   end

   // Overlay group: only reset sets it, so a late clear can never be undone
   always_comb begin
      next_overlay = overlay;
      if (i_overlay_clear) begin
         next_overlay = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         overlay <= sbbm_pkg::OVERLAY_RESET;
      end else begin
         overlay <= next_overlay;
      end
   end

   // Hazard group: only the edge just before matters for a one-cycle stall
   always_comb begin
      next_last_wr   = sram.wr_en;
      next_last_bank = cur_addr[0];
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         last_wr   <= 1'b0;
         last_bank <= 1'b0;
      end else begin
         last_wr   <= next_last_wr;
         last_bank <= next_last_bank;
      end
   end

   // Pending group: a stalled read is replayed to the banks one cycle later
   always_comb begin
      next_pend_addr = pend_addr;
      next_pend_bb   = pend_bb;
      next_pend_bit  = pend_bit;
      if (take && sram_hit && !i_write && same_bank_stall) begin
         next_pend_addr = cur_addr;
         next_pend_bb   = cur_bb;
         next_pend_bit  = cur_bit;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pend_addr <= '0;
         pend_bb   <= 1'b0;
         pend_bit  <= 5'h00;
      end else begin
         pend_addr <= next_pend_addr;
         pend_bb   <= next_pend_bb;
         pend_bit  <= next_pend_bit;
      end
   end

   // Boot pin: pins are asynchronous, so two flops before the selector
   logic [63:0] gpio_meta, gpio_sync;
   logic [5:0]  pin_sel;
   logic        pin_level, pin_match;
   logic        next_pin_level, next_pin_match;

   assign pin_sel = {i_boot_config_word[sbbm_pkg::CFG_PORT_LSB +: 3],
                     i_boot_config_word[sbbm_pkg::CFG_PIN_LSB +: 3]};

   always_comb begin
      next_pin_level = gpio_sync[pin_sel];
      next_pin_match = i_boot_config_word[sbbm_pkg::CFG_EN_BIT]
                       && (gpio_sync[pin_sel] == i_boot_config_word[sbbm_pkg::CFG_POL_BIT]);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gpio_meta <= 64'h0000_0000_0000_0000;
         gpio_sync <= 64'h0000_0000_0000_0000;
         pin_level <= 1'b0;
         pin_match <= 1'b0;
      end else begin
         gpio_meta <= i_gpio;
         gpio_sync <= gpio_meta;
         pin_level <= next_pin_level;
         pin_match <= next_pin_match;
      end
   end

   assign o_busy           = busy;
   assign o_ack            = ack;
   assign o_error          = error;
   assign o_rdata          = rdata;
   assign o_code_req       = code_req;
   assign o_code_rom       = code_rom;
   assign o_code_addr      = code_addr;
   assign o_rom_overlay    = overlay;
   assign o_boot_pin_level = pin_level;
   assign o_boot_pin_match = pin_match;

endmodule : sbbm_top

// ### sbbm_pkg.sv
// Shared constants and types of the SRAM, bit alias and boot map decoder.
// Assumes one system clock and byte addresses as seen on the core's bus.
package sbbm_pkg;

   localparam logic [31:0] SRAM_BASE          = 32'h2000_0000;
   localparam logic [31:0] SRAM_BYTES         = 32'h0000_C000;
   localparam logic [31:0] BITBAND_BASE       = 32'h2200_0000;
   localparam int          BITBAND_BYTE_SHIFT = 5;
   localparam logic [31:0] ROM_BASE           = 32'h0100_0000;
   localparam logic [31:0] ROM_BYTES          = 32'h0001_0000;
   localparam logic [31:0] FLASH_BASE         = 32'h0000_0000;
   localparam logic [31:0] FLASH_BYTES        = 32'h0004_0000;
   localparam logic [31:0] ROM_API_TABLE_ADDR = 32'h0100_0010;
   localparam logic [31:0] API_SEC_BASE       = 32'h0000_0100;
   localparam logic [31:0] API_SEC_SIZE       = 32'h0000_0100;
   localparam int          API_PERIPHS        = 16;
   localparam logic [31:0] BOOT_VECTOR_ADDR   = 32'h0000_0004;
   localparam logic [31:0] BLANK_FLASH_WORD   = 32'hFFFF_FFFF;

   // Fields of the boot configuration word
   localparam int          CFG_EN_BIT         = 8;
   localparam int          CFG_POL_BIT        = 9;
   localparam int          CFG_PORT_LSB       = 10;
   localparam int          CFG_PIN_LSB        = 13;

   localparam logic        OVERLAY_RESET      = 1'b1;

   typedef enum logic [4:0] {
      REG_NONE  = 5'h01,
      REG_SRAM  = 5'h02,
      REG_ALIAS = 5'h04,
      REG_ROM   = 5'h08,
      REG_FLASH = 5'h10
   } sbbm_region_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_STALL = 3'h2,
      ST_CODE  = 3'h4
   } sbbm_state_t;

endpackage : sbbm_pkg

// ### sbbm_sram_if.sv
// Port between the decoder and its two-bank SRAM.
// Assumes the decoder drives one access per cycle; read data is combinational.
`timescale 1ns/100ps
interface sbbm_sram_if #(parameter int AW = 14);
   logic          wr_en;
   logic          bitband;
   logic [AW-1:0] addr;
   logic [4:0]    bit_idx;
   logic [3:0]    be;
   logic [31:0]   wdata;
   logic [31:0]   rdata;

   modport ctrl (output wr_en, bitband, addr, bit_idx, be, wdata, input rdata);
   modport mem  (input wr_en, bitband, addr, bit_idx, be, wdata, output rdata);
endinterface : sbbm_sram_if

// ### sbbm_sram_banks.sv
// Two 32-bit SRAM banks, even words in bank 0 and odd words in bank 1.
// Assumes word index bit 0 picks the bank; contents are not reset.
`timescale 1ns/100ps
module sbbm_sram_banks #(
   parameter int WORDS = 12288,
   parameter int AW    = 14
) (
   input  wire logic i_clk,
   sbbm_sram_if.mem  bus
);
   localparam int IW = $clog2(WORDS / 2);

   logic [31:0] bank_q [2][WORDS/2];
   logic [31:0] next_word;
   logic [IW-1:0] row;

   assign row       = bus.addr[IW:1];
   assign bus.rdata = bank_q[bus.addr[0]][row];

   // Bit alias write changes one bit in place, no requester read-modify-write
   always_comb begin
      next_word = bus.rdata;
      if (bus.bitband) begin
         next_word[bus.bit_idx] = bus.wdata[0];
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (bus.be[b]) begin
               next_word[b*8 +: 8] = bus.wdata[b*8 +: 8];
            end
         end
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_bank
      always_ff @(posedge i_clk) begin
         if (bus.wr_en && (bus.addr[0] == 1'(g))) begin
            bank_q[g][row] <= next_word;
         end
      end
   end

endmodule : sbbm_sram_banks

// ### sbbm_code_model.sv
// Behavioural code memory on the far side of the decoder's code port.
// Assumes the decoder samples data in the same cycle as its fetch strobe.
`timescale 1ns/100ps
module sbbm_code_model (
   input  wire logic        i_clk,
   input  wire logic        i_req,
   input  wire logic        i_rom,
   input  wire logic [31:0] i_addr,
   output logic      [31:0] o_rdata
);
   logic [31:0] junk = 32'h0;
   // Moving pattern outside a fetch, so stale data never passes for good data
   always @(posedge i_clk) junk <= junk + 32'h1357_9BDF;
   assign o_rdata = i_req ? {i_rom ? 8'hC5 : 8'hF1, i_addr[23:0]} : junk;
endmodule : sbbm_code_model

// ### sbbm_top_checker.sv
// Port checker for the memory decoder.
// Assumes it is bound to sbbm_top and sees only its ports.
`timescale 1ns/100ps
module sbbm_top_checker (
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   input wire logic        i_req,
   input wire logic        i_write,
   input wire logic        i_dma,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_code_rdata,
   input wire logic        i_overlay_clear,
   input wire logic        o_busy,
   input wire logic        o_ack,
   input wire logic        o_error,
   input wire logic [31:0] o_rdata,
   input wire logic        o_code_req,
   input wire logic        o_code_rom,
   input wire logic [31:0] o_code_addr,
   input wire logic        o_rom_overlay
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Taken only while no stall or code fetch is pending
   wire logic tk = i_req && !o_busy;
   wire logic rd = tk && !i_write && !i_dma;
   sram_wr_a : assert property (
      tk && i_write && !i_dma && i_addr >= 32'h2000_0000 && i_addr < 32'h2000_C000 |=> o_ack && !o_error)
      else $error("sram write not answered");
   stall_len_a : assert property (o_busy |=> o_ack && !o_busy)
      else $error("stall not one cycle");
   same_bank_a : assert property (
      tk && i_write && i_addr >= 32'h2000_0000 && i_addr < 32'h2000_C000
      ##1 rd && i_addr >= 32'h2000_0000 && i_addr < 32'h2000_C000 && i_addr[2] == $past(i_addr[2])
      |=> o_busy && !o_ack) else $error("same bank read not stalled");
   other_bank_a : assert property (
      tk && i_write && i_addr >= 32'h2000_0000 && i_addr < 32'h2000_C000
      ##1 rd && i_addr >= 32'h2000_0000 && i_addr < 32'h2000_C000 && i_addr[2] != $past(i_addr[2])
      |=> o_ack && !o_busy) else $error("other bank read stalled");
   code_data_a : assert property (
      o_code_req && o_code_addr > 32'h4F |=> o_ack && o_rdata == $past(i_code_rdata))
      else $error("code data not returned");
   ovl_map_a : assert property (
      rd && o_rom_overlay && i_addr > 32'h4F && i_addr < 32'h0004_0000
      |=> o_code_req && o_code_rom && o_code_addr == $past(i_addr)) else $error("overlay fetch wrong");
   rom_map_a : assert property (
      rd && i_addr >= 32'h0100_0100 && i_addr < 32'h0101_0000
      |=> o_code_req && o_code_rom && o_code_addr == $past(i_addr) - 32'h0100_0000) else $error("rom fetch wrong");
   dma_ref_a : assert property (tk && i_dma && i_addr < 32'h0101_0000 |=> o_ack && o_error)
      else $error("dma code access not refused");
   err_zero_a : assert property (o_error |-> o_ack && o_rdata == 32'h0)
      else $error("error without ack or zero data");
   alias_bit_a : assert property (
      rd && i_addr >= 32'h2200_0000 && i_addr < 32'h2218_0000 |-> ##[1:2] o_ack && o_rdata[31:1] == 31'h0)
      else $error("alias read upper bits set");
   ovl_clr_a : assert property (i_overlay_clear |=> !o_rom_overlay)
      else $error("overlay not cleared");
   ovl_stay_a : assert property (!o_rom_overlay |=> !o_rom_overlay)
      else $error("overlay came back");
   cover property (o_busy && !o_code_req);
   cover property (o_code_req);
   cover property (o_error);
endmodule : sbbm_top_checker
bind sbbm_top sbbm_top_checker chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .i_write(i_write),
   .i_dma(i_dma), .i_addr(i_addr), .i_code_rdata(i_code_rdata), .i_overlay_clear(i_overlay_clear),
   .o_busy(o_busy), .o_ack(o_ack), .o_error(o_error), .o_rdata(o_rdata), .o_code_req(o_code_req),
   .o_code_rom(o_code_rom), .o_code_addr(o_code_addr), .o_rom_overlay(o_rom_overlay));

// ### sram_bitband_boot_map_test.sv
// Self-checking bench for the memory decoder with a code memory model.
// Assumes answers are collected by a monitor and matched to taking edges in order.
`timescale 1ns/100ps
module sram_bitband_boot_map_test;
   logic        i_clk = 1'b0, i_reset_n = 1'b0, i_req = 1'b0, i_write = 1'b0, i_dma = 1'b0, ovl_clr = 1'b0;
   logic [31:0] i_addr = 32'h0, i_wdata = 32'h0, cfg = 32'h0, o_rdata, o_code_addr, code_rdata, rv, d, d2;
   logic [63:0] gpio = 64'h0;
   logic        o_busy, o_ack, o_error, o_code_req, o_code_rom, o_rom_overlay, o_lvl, o_match, ev, lv;
   logic [2:0]  pin;
   logic [32:0] rq[$];
   int          bad_count = 0, comparisons = 0, cyc = 0, lat, w, o, bo, bt, tq[$], cq[$];
   always #2.5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_ack === 1'b1) begin
         rq.push_back({o_error, o_rdata});
         cq.push_back(cyc);
      end
   end
   sbbm_top uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .i_write(i_write), .i_dma(i_dma),
      .i_addr(i_addr), .i_be(4'hF), .i_wdata(i_wdata), .o_busy(o_busy), .o_ack(o_ack), .o_error(o_error),
      .o_rdata(o_rdata), .o_code_req(o_code_req), .o_code_rom(o_code_rom), .o_code_addr(o_code_addr),
      .i_code_rdata(code_rdata), .i_overlay_clear(ovl_clr), .o_rom_overlay(o_rom_overlay),
      .i_boot_config_word(cfg), .i_gpio(gpio), .o_boot_pin_level(o_lvl), .o_boot_pin_match(o_match));
   sbbm_code_model model (.i_clk(i_clk), .i_req(o_code_req), .i_rom(o_code_rom), .i_addr(o_code_addr),
      .o_rdata(code_rdata));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic take(input logic wr, input logic dm, input logic [31:0] a, input logic [31:0] wd);
      i_req   <= 1'b1;
      i_write <= wr;
      i_dma   <= dm;
      i_addr  <= a;
      i_wdata <= wd;
      @(posedge i_clk);
      while (o_busy === 1'b1) @(posedge i_clk);
      tq.push_back(cyc);
   endtask : take
   task automatic idle();
      i_req <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask : idle
   task automatic pop();
      chk(rq.size() > 0, 1'b1);
      if (rq.size() > 0) begin
         {ev, rv} = rq.pop_front();
         lat = cq.pop_front() - tq.pop_front();
      end
   endtask : pop
   task automatic op(input logic wr, input logic dm, input logic [31:0] a, input logic [31:0] wd);
      take(wr, dm, a, wd);
      idle();
      pop();
   endtask : op
   task automatic errop(input logic wr, input logic dm, input logic [31:0] a);
      op(wr, dm, a, 32'h5);
      chk({ev, rv}, 33'h1_0000_0000);
   endtask : errop
   task automatic endt(input string name);
      $display("test %s finished", name);
   endtask : endt
   function automatic logic [31:0] code_word(input logic rom, input logic [31:0] a);
      return {rom ? 8'hC5 : 8'hF1, a[23:0]};
   endfunction : code_word
   function automatic logic [31:0] sram(input int wi);
      return sbbm_pkg::SRAM_BASE + 32'(wi) * 4;
   endfunction : sram
   task automatic test_done();
      $display("checks %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   initial begin
      #100000;
      bad_count++;
      test_done();
   end
   initial begin
      lat = $urandom(77519);
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      chk(o_rom_overlay, 1'b1);
      op(0, 0, 32'h0000_0100, 0);
      chk({lat[7:0], rv}, {8'h2, code_word(1, 32'h100)});
      for (int i = 0; i < 16; i += 5) begin
         op(0, 0, sbbm_pkg::ROM_API_TABLE_ADDR + 32'(i) * 4, 0);
         chk(rv, 32'h0100_0100 + 32'(i) * 32'h100);
      end
      ovl_clr <= 1'b1;
      @(posedge i_clk);
      ovl_clr <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk(o_rom_overlay, 1'b0);
      op(0, 0, 32'h4, 0);
      chk(rv, code_word(0, 32'h4));
      op(0, 0, 32'h0, 0);
      chk({lat[7:0], rv}, {8'h2, code_word(0, 32'h0)});
      op(0, 0, 32'h0100_0200, 0);
      chk(rv, code_word(1, 32'h200));
      errop(0, 1, 32'h0100_0200);
      errop(0, 1, 32'h0000_0040);
      errop(1, 0, 32'h4);
      errop(0, 0, 32'h3000_0000);
      endt("code map");
      for (int n = 0; n < 40; n++) begin
         w = $urandom % 12288;
         o = n % 2 ? w ^ 1 : w ^ 2;
         d = $urandom;
         d2 = $urandom;
         op(1, 1, sram(o), d2);
         chk(ev, 1'b0);
         take(1, 0, sram(w), d);
         take(0, 0, sram(o), 0);
         idle();
         pop();
         chk(lat, 1);
         pop();
         chk({lat[7:0], rv}, {n % 2 ? 8'h1 : 8'h2, d2});
         op(0, 0, sram(w), 0);
         chk(rv, d);
      end
      endt("sram banks");
      for (int n = 0; n < 16; n++) begin
         bo = $urandom % 49152;
         bt = $urandom % 8;
         d = $urandom;
         op(1, 0, sram(bo / 4), d);
         op(0, 0, sbbm_pkg::BITBAND_BASE + 32'(bo) * 32 + 32'(bt) * 4, 0);
         chk(rv, d[(bo % 4) * 8 + bt]);
         op(1, 0, sbbm_pkg::BITBAND_BASE + 32'(bo) * 32 + 32'(bt) * 4, {31'($urandom), ~rv[0]});
         op(0, 0, sram(bo / 4), 0);
         chk(rv, d ^ (32'h1 << ((bo % 4) * 8 + bt)));
      end
      endt("bit alias");
      for (int p = 0; p < 8; p++) begin
         pin = 3'($urandom);
         gpio <= {$urandom, $urandom};
         cfg <= {16'h0, pin, 3'(p), 1'($urandom), 1'(p % 3 != 0), 8'h0};
         repeat (5) @(posedge i_clk);
         lv = gpio[p * 8 + pin];
         chk(o_lvl, lv);
         chk(o_match, cfg[8] && lv == cfg[9]);
      end
      endt("boot pin");
      test_done();
   end
endmodule : sram_bitband_boot_map_test
